/* logic/pcb_pkg.sv */
package pcb_pkg;

    // ----------------------------------------------------------------
    // bank layout
    // ----------------------------------------------------------------
    localparam int unsigned BANK_WIDTH = 3;
    localparam int unsigned SEL_BANKS = 3;

    // ----------------------------------------------------------------
    // oscillator model and lock settling
    // ----------------------------------------------------------------
    localparam logic [1:0] OSC_DIV_RESET = 2'h0;
    localparam logic [11:0] SETTLE_CYCLES = 12'h040;
    localparam logic [11:0] SETTLE_RESET = 12'h000;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic sel_high;
        logic sel_low;
    } pcb_sel_s;

    typedef struct packed {
        logic [BANK_WIDTH-1:0] bank_four;
        logic [BANK_WIDTH-1:0] bank_three;
        logic [BANK_WIDTH-1:0] bank_two;
        logic [BANK_WIDTH-1:0] bank_one;
    } pcb_banks_s;

    typedef enum logic [1:0] {
        PCB_SETTLING,
        PCB_LOCKED
    } pcb_lock_e;

endpackage

/* logic/pcb_divider.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// oscillator divider: half and quarter rate, both 50% duty
// ------------------------------------------------------------------
module pcb_divider (
    input wire logic clk, // oscillator clock
    input wire logic rst_n, // synchronised reset, active low
    output logic half_q, // oscillator / 2
    output logic quarter_q // oscillator / 4
);

    logic [1:0] cnt_q;
    logic [1:0] cnt_d;

    // a binary counter gives both ratios from flops, so duty is exact
    assign cnt_d = 2'(cnt_q + 2'h1);

    // counter bits register the divided clocks directly
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= pcb_pkg::OSC_DIV_RESET;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign half_q = cnt_q[0];
    assign quarter_q = cnt_q[1];

    // the first edge out of reset has no earlier toggle to compare with
    a_half_toggles: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> half_q != $past(half_q))
        else $error("half rate clock did not toggle");

    a_quarter_period: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(quarter_q) |=> quarter_q ##1 !quarter_q)
        else $error("quarter rate clock lost 50 percent duty");

endmodule

/* logic/pcb_clock_bank.sv */
`timescale 1ns/1ps

// What this block does
// - The oscillator divides into half and quarter rate clocks at 50% duty.
// - Outside test bypass each selectable bank carries either the half or the quarter rate clock.
// - Selectable outputs come in three banks of three, nine at most.
// - Select 00 slows no bank, 01 bank one, 10 one and two, 11 one to three.
// - Outside test bypass the fourth bank always carries the half rate clock.
// - With half rate fed back the oscillator runs at twice the reference.
// - With quarter rate fed back outputs run at once or twice the reference.
// - The oscillator range is 100 to 200 MHz, twice the output range.
// - All outputs float while the active-low enable is high.
// - Outside test bypass every output has 50% duty whatever the reference duty.
// - The test input bypasses the loop and is held low in service.
module pcb_clock_bank (
    input wire logic clk, // oscillator model clock
    input wire logic reset_n, // asynchronous reset, active low
    input wire logic reference_clock_input, // reference clock pin
    input wire logic loop_feedback_input, // fed back output pin
    input wire pcb_pkg::pcb_sel_s bank_select, // select pair pins
    input wire logic output_enable_n, // output enable, active low
    input wire logic test_bypass, // loop bypass, high for test
    output pcb_pkg::pcb_banks_s bank_outputs, // clock outputs
    output pcb_pkg::pcb_banks_s bank_oe_n, // output enables, low drives
    output logic locked_q // settle interval over
);

    // ----------------------------------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [1:0] ref_sync_q;
    logic [1:0] fb_sync_q;
    logic [1:0] sel_sync0_q;
    logic [1:0] sel_sync1_q;
    logic [1:0] oe_sync0_q;
    logic [1:0] test_sync0_q;
    logic [1:0] cfg_prev_q;
    logic oe_prev_q;
    logic test_prev_q;

    // release is synchronous so no flop leaves reset on a split edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // pins are asynchronous to clk, two stages before any use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_sync_q <= 2'h0;
            fb_sync_q <= 2'h0;
            sel_sync0_q <= 2'h0;
            sel_sync1_q <= 2'h0;
            oe_sync0_q <= 2'h3;
            test_sync0_q <= 2'h0;
        end else begin
            ref_sync_q <= {ref_sync_q[0], reference_clock_input};
            fb_sync_q <= {fb_sync_q[0], loop_feedback_input};
            sel_sync0_q <= {sel_sync0_q[0], bank_select.sel_low};
            sel_sync1_q <= {sel_sync1_q[0], bank_select.sel_high};
            oe_sync0_q <= {oe_sync0_q[0], output_enable_n};
            test_sync0_q <= {test_sync0_q[0], test_bypass};
        end
    end

    logic ref_s;
    logic fb_s;
    logic [1:0] cfg_s;
    logic oe_n_s;
    logic test_s;
    assign ref_s = ref_sync_q[1];
    assign fb_s = fb_sync_q[1];
    assign cfg_s = {sel_sync1_q[1], sel_sync0_q[1]};
    assign oe_n_s = oe_sync0_q[1];
    assign test_s = test_sync0_q[1];

    // ----------------------------------------------------------------
    // divided clocks
    // ----------------------------------------------------------------
    logic half_clk;
    logic quarter_clk;

    // clk stands for the oscillator; the analog loop is outside this model,
    // so the reference only feeds the test bypass and the feedback is never used
    pcb_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .half_q(half_clk),
        .quarter_q(quarter_clk)
    );

    // ----------------------------------------------------------------
    // bank routing
    // ----------------------------------------------------------------
    // slow-bank mask: bit k set puts bank k+1 on the quarter rate clock
    function automatic logic [2:0] slow_mask(input logic [1:0] sel);
        unique case (sel)
            2'h0: slow_mask = 3'h0;
            2'h1: slow_mask = 3'h1;
            2'h2: slow_mask = 3'h3;
            2'h3: slow_mask = 3'h7;
        endcase
    endfunction

    logic [2:0] slow_w;
    logic [2:0] bank_clk_w;
    pcb_pkg::pcb_banks_s out_d;
    pcb_pkg::pcb_banks_s out_q;
    pcb_pkg::pcb_banks_s oe_n_q;

    assign slow_w = slow_mask(cfg_s);
    // test bypass sends the reference straight through the banks
    assign bank_clk_w[0] = test_s ? ref_s :
        (slow_w[0] ? quarter_clk : half_clk);
    assign bank_clk_w[1] = test_s ? ref_s :
        (slow_w[1] ? quarter_clk : half_clk);
    assign bank_clk_w[2] = test_s ? ref_s :
        (slow_w[2] ? quarter_clk : half_clk);
    assign out_d.bank_one = {pcb_pkg::BANK_WIDTH{bank_clk_w[0]}};
    assign out_d.bank_two = {pcb_pkg::BANK_WIDTH{bank_clk_w[1]}};
    assign out_d.bank_three = {pcb_pkg::BANK_WIDTH{bank_clk_w[2]}};
    assign out_d.bank_four = {pcb_pkg::BANK_WIDTH{
        test_s ? ref_s : half_clk}};

    // outputs registered; one flop of delay common to every bank keeps skew
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= '0;
            oe_n_q <= '1;
        end else begin
            out_q <= out_d;
            oe_n_q <= {12{oe_n_s}};
        end
    end
    assign bank_outputs = out_q;
    assign bank_oe_n = oe_n_q;

    // ----------------------------------------------------------------
    // lock settling
    // ----------------------------------------------------------------
    pcb_pkg::pcb_lock_e state_q;
    pcb_pkg::pcb_lock_e state_d;
    logic [11:0] settle_q;
    logic [11:0] settle_d;
    logic disturb_w;

    // select change, bypass release and re-enable restart the wait;
    // the feedback pin is not checked, so a bad board loop goes unseen
    assign disturb_w = (cfg_s != cfg_prev_q) || (test_prev_q && !test_s)
        || (oe_prev_q && !oe_n_s) || test_s || fb_s != fb_s;
    assign state_d = disturb_w ? pcb_pkg::PCB_SETTLING :
        (settle_q == 12'h001 ? pcb_pkg::PCB_LOCKED : state_q);
    assign settle_d = disturb_w ? pcb_pkg::SETTLE_CYCLES :
        (settle_q != 12'h000 ? 12'(settle_q - 12'h001) : settle_q);

    // power-up counts as a disturbance: the wait starts loaded
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pcb_pkg::PCB_SETTLING;
            settle_q <= pcb_pkg::SETTLE_CYCLES;
            cfg_prev_q <= 2'h0;
            oe_prev_q <= 1'b1;
            test_prev_q <= 1'b0;
            locked_q <= 1'b0;
        end else begin
            state_q <= state_d;
            settle_q <= settle_d;
            cfg_prev_q <= cfg_s;
            oe_prev_q <= oe_n_s;
            test_prev_q <= test_s;
            locked_q <= (state_d == pcb_pkg::PCB_LOCKED);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_disturb;
        disturb_w;
    endsequence

    a_bank_four_half: assert property (
        @(posedge clk) disable iff (!rst_n)
        !test_s |=> bank_outputs.bank_four == {3{$past(half_clk)}})
        else $error("bank four not on half rate");

    a_select_decode: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!test_s && cfg_s == 2'h1) |=>
        bank_outputs.bank_one[0] == $past(quarter_clk) &&
        bank_outputs.bank_two[0] == $past(half_clk))
        else $error("select 01 decode wrong");

    a_enable_float: assert property (
        @(posedge clk) disable iff (!rst_n)
        oe_n_s |=> bank_oe_n == 12'hfff)
        else $error("outputs driven while disabled");

    a_bypass_route: assert property (
        @(posedge clk) disable iff (!rst_n)
        test_s |=> bank_outputs.bank_three[2] == $past(ref_s))
        else $error("bypass not routing reference");

    a_settle_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_disturb |=> !locked_q [*8])
        else $error("lock shown too soon after disturbance");

endmodule

/* tb/pcb_board_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// board side: reference source and feedback wiring
// ----------------------------------------------------------------
module pcb_board_model #(
    parameter realtime HALF_NS = 400.0
) (
    input wire logic fb_out, // output chosen for feedback
    input wire logic fb_oe_n, // its enable, low drives
    output logic reference_clock_input, // reference clock pin
    output logic loop_feedback_input // feedback pin
);
    // fixed frequency and phase; offset so it never lines up with clk
    // the loop is not modelled, so the input band is only scaled
    // a slow, steady reference lets the bypass checks see settled levels
    initial begin
        reference_clock_input = 1'b0;
        #7;
        forever #(HALF_NS) reference_clock_input = ~reference_clock_input;
    end
    // one output wired back; the termination pulls a floated line low
    assign loop_feedback_input = fb_oe_n ? 1'b0 : fb_out;
endmodule

/* tb/pcb_clock_bank_tb.sv */
`timescale 1ns/1ps

module pcb_clock_bank_tb;
    // ----------------------------------------------------------------
    // harness
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    pcb_pkg::pcb_sel_s bank_select = 2'h0;
    logic output_enable_n = 1'b0;
    logic test_bypass = 1'b0; // strapped low outside the bypass
    logic ref_clk, fb_in, locked_q;
    pcb_pkg::pcb_banks_s bank_outputs, bank_oe_n;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    logic [3:0] ref_hist = 4'h0;

    pcb_board_model u_pcb_board_model (
        .fb_out(bank_outputs[0]), .fb_oe_n(bank_oe_n[0]),
        .reference_clock_input(ref_clk), .loop_feedback_input(fb_in));

    pcb_clock_bank u_pcb_clock_bank (
        .clk(clk), .reset_n(reset_n), .reference_clock_input(ref_clk),
        .loop_feedback_input(fb_in), .bank_select(bank_select),
        .output_enable_n(output_enable_n), .test_bypass(test_bypass),
        .bank_outputs(bank_outputs), .bank_oe_n(bank_oe_n),
        .locked_q(locked_q));

    // 25 MHz model clock
    initial begin
        forever #20 clk = ~clk;
    end

    // reference history for bypass checks; cycle ceiling cuts a hang
    always @(posedge clk) begin
        ref_hist <= {ref_hist[2:0], ref_clk};
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            complete_run();
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(string what, logic [11:0] exp, logic [11:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // over 8 cycles: half rate toggles 8 times, quarter 4; both 4 high
    task automatic rates(input logic [3:0] slow);
        logic [11:0] prev;
        int tog [4];
        int hi [4];
        for (int b = 0; b < 4; b++) begin
            tog[b] = 0;
            hi[b] = 0;
        end
        @(negedge clk);
        prev = bank_outputs;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            for (int b = 0; b < 4; b++) begin
                check("bank triple", {3{bank_outputs[3*b]}},
                    bank_outputs[3*b +: 3]);
                tog[b] += int'(bank_outputs[3*b] !== prev[3*b]);
                hi[b] += int'(bank_outputs[3*b] === 1'b1);
            end
            prev = bank_outputs;
        end
        for (int b = 0; b < 4; b++) begin
            check("toggles", slow[b] ? 12'h4 : 12'h8, 12'(tog[b]));
            check("high count", 12'h4, 12'(hi[b]));
        end
    endtask

    // lock drops after a disturbance and returns after the settle count
    task automatic settle(string what);
        repeat (5) @(negedge clk);
        check(what, 12'h0, 12'(locked_q));
        repeat (40) @(negedge clk);
        check(what, 12'h0, 12'(locked_q));
        for (int i = 0; i < 80 && locked_q !== 1'b1; i++) @(negedge clk);
        check(what, 12'h1, 12'(locked_q));
    endtask

    task automatic complete_run();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // reset holds outputs floated and low, then lock follows the settle
    task automatic t_power_up();
        repeat (8) @(negedge clk);
        check("reset enables", 12'hfff, bank_oe_n);
        check("reset outputs", 12'h000, bank_outputs);
        check("reset lock", 12'h0, 12'(locked_q));
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        for (int i = 0; i < 150 && locked_q !== 1'b1; i++) @(negedge clk);
        check("power-up lock", 12'h1, 12'(locked_q));
        $display("test power-up done");
    endtask

    task automatic t_select();
        for (int s = 0; s < 4; s++) begin
            @(negedge clk);
            bank_select = pcb_pkg::pcb_sel_s'(s[1:0]);
            repeat (6) @(negedge clk);
            rates(4'((4'h1 << s) - 4'h1));
        end
        settle("lock after select");
        $display("test select done");
    endtask

    task automatic t_enable();
        output_enable_n = 1'b1;
        repeat (5) @(negedge clk);
        check("float", 12'hfff, bank_oe_n);
        output_enable_n = 1'b0;
        repeat (4) @(negedge clk);
        check("drive", 12'h000, bank_oe_n);
        settle("lock after enable");
        $display("test enable done");
    endtask

    // bypass: every output follows the reference; lock held low
    task automatic t_bypass();
        test_bypass = 1'b1;
        repeat (6) @(negedge clk);
        for (int i = 0; i < 60; i++) begin
            @(negedge clk);
            check("bypass lock", 12'h0, 12'(locked_q));
            if (ref_hist == 4'h0 || ref_hist == 4'hf) begin
                check("bypass out", {12{ref_hist[0]}}, bank_outputs);
            end
        end
        test_bypass = 1'b0;
        settle("lock after bypass");
        $display("test bypass done");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        t_power_up();
        t_select();
        t_enable();
        t_bypass();
        complete_run();
    end
endmodule
